/* File: rtl/dmabi_top.sv */
// Bus-side interface and operating-mode control of the DMA controller
// Notes on behaviour
// - Always exactly one mode: host access, bus master or idle.
// - Host access while chip-selected or driving an interrupt vector.
// - Bus master mode while owning the bus for operand cycles.
// - Idle after reset; most bus controls three-stated.
// - Upper address shares data pins; strobes let outside logic separate them.
// - Low address pins select registers in host mode, carry address in bus master mode.
// - Function codes driven only during own bus cycles.
// - Chip select during own cycle ends it with an address error.
// - Address strobe is input in host mode, output in own cycles, watched in arbitration.
// - Upper address latch strobe floats outside bus master mode.
// - Ownership output asserted through bus master mode, floats otherwise.
// - Data direction and buffer enable float only in idle.
// - Upper byte route asserted for byte data on upper lanes; floats outside bus master mode.
// - Read/write is input in host mode, output as master, floats idle.
// - Byte strobes pick bytes and stand in for address bit zero.
// - Exception code and acknowledge inputs sampled on rising edges, other bus pins except the control line on falling edges.
// - Start pulse drives the control line low for four clocks.
// - Eight and sixteen bit ports; operands staged in internal buffer.
// - Cycle ends on acknowledge; earlier non-halt exception wins over it.
// - Acknowledge driven in host mode, floats in idle.
// - Take bus only after strobe and grant acknowledge go inactive.
// - Transfer complete pulses on normal end without exception.
`include "dmabi_map.svh"
module dmabi_top (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Multiplexed address and data
   input wire logic [15:0] ad_i,
   output logic [15:0] ad_o,
   output logic ad_oe,
   input wire logic [6:0] addr_lo_i,
   output logic [6:0] addr_lo_o,
   output logic addr_lo_oe,
   // Bus strobes
   input wire logic address_strobe_n_i,
   output logic address_strobe_n_o,
   output logic address_strobe_n_oe,
   input wire logic upper_byte_strobe_n_i,
   output logic upper_byte_strobe_n_o,
   input wire logic lower_byte_strobe_n_i,
   output logic lower_byte_strobe_n_o,
   output logic byte_strobe_oe,
   input wire logic rw_i,
   output logic rw_o,
   output logic rw_oe,
   input wire logic transfer_acknowledge_n_i,
   output logic transfer_acknowledge_n_o,
   output logic transfer_acknowledge_n_oe,
   // Demultiplex controls
   output logic upper_address_latch_strobe_n_o,
   output logic upper_address_latch_strobe_n_oe,
   output logic own_n_o,
   output logic own_n_oe,
   output logic data_direction_out_o,
   output logic data_direction_out_oe,
   output logic data_buffer_enable_out_n_o,
   output logic data_buffer_enable_out_n_oe,
   output logic upper_byte_route_n_o,
   output logic upper_byte_route_n_oe,
   output logic [2:0] function_code_out_o,
   output logic function_code_out_oe,
   output logic transfer_complete_out_n_o,
   output logic transfer_complete_out_n_oe,
   // Arbitration and select
   output logic bus_request_n_o,
   input wire logic bus_grant_in_n,
   input wire logic grant_acknowledge_n_i,
   output logic grant_acknowledge_n_o,
   output logic grant_acknowledge_n_oe,
   input wire logic chip_select_n,
   input wire logic interrupt_acknowledge_in_n,
   input wire logic [2:0] bus_exception_code_n,
   // Peripheral control line
   input wire logic peripheral_control_line_n_i,
   output logic peripheral_control_line_n_o,
   output logic peripheral_control_line_n_oe,
   input wire logic start_cfg,
   input wire logic start_trig,
   // Operand cycle requests
   input wire logic req_valid,
   output logic req_ready,
   input wire logic [23:1] req_addr,
   input wire logic req_write,
   input wire logic [2:0] req_fc,
   input wire logic req_upper,
   input wire logic req_lower,
   input wire logic req_upper_byte_route,
   input wire logic [15:0] req_wdata,
   output logic cyc_done,
   output logic bus_err,
   output logic addr_err,
   // Read data out
   output logic rd_valid,
   input wire logic rd_ready,
   output logic [15:0] rd_data,
   // Register access
   output logic reg_stb,
   output logic reg_write,
   output logic reg_interrupt_acknowledge_in,
   output logic [7:0] reg_addr,
   output logic [15:0] reg_wdata,
   input wire logic [15:0] reg_rdata,
   input wire logic vec_pending,
   // Status
   output dmabi_pkg::dmabi_mode_t mode
);
   // ---------------------------------------------------------------
   // Input sampling
   // ---------------------------------------------------------------
   logic [`DMABI_IN_A_W-1:0] in_a_s;
   logic [`DMABI_IN_B_W-1:0] in_b_s;
   dmabi_sync #(.W(`DMABI_IN_A_W), .FALL(1'b1)) u_sync_a (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_i({bus_grant_in_n, grant_acknowledge_n_i, chip_select_n,
              interrupt_acknowledge_in_n, address_strobe_n_i, upper_byte_strobe_n_i,
              lower_byte_strobe_n_i, rw_i, addr_lo_i, ad_i}),
      .sync_o(in_a_s)
   );
   dmabi_sync #(.W(`DMABI_IN_B_W), .FALL(1'b0)) u_sync_b (
      .clk(clk),
      .sys_rst(sys_rst),
      .pin_i({bus_exception_code_n, transfer_acknowledge_n_i}),
      .sync_o(in_b_s)
   );
   wire bg_s = in_a_s[30];
   wire grant_acknowledge_s = in_a_s[29];
   wire cs_s = in_a_s[28];
   wire interrupt_acknowledge_in_s = in_a_s[27];
   wire as_s = in_a_s[26];
   wire uds_s = in_a_s[25];
   wire lds_s = in_a_s[24];
   wire rw_s = in_a_s[23];
   wire [6:0] alo_s = in_a_s[22:16];
   wire [15:0] ad_s = in_a_s[15:0];
   wire [2:0] bec_s = in_b_s[3:1];
   wire transfer_acknowledge_s = in_b_s[0];

   function automatic logic exc_taken(input logic [2:0] code);
      exc_taken = (code != `DMABI_BEC_NONE) && (code != `DMABI_BEC_HALT);
   endfunction

   // ---------------------------------------------------------------
   // Host access sequencer
   // ---------------------------------------------------------------
   dmabi_pkg::dmabi_hst_t h_st_q, h_st_d;
   dmabi_pkg::dmabi_mst_t m_st_q, m_st_d;
   wire m_owns = (m_st_q == dmabi_pkg::M_ADDR) || (m_st_q == dmabi_pkg::M_DATA) ||
                 (m_st_q == dmabi_pkg::M_END);
   wire host_go = !as_s && (!cs_s || (!interrupt_acknowledge_in_s && vec_pending)) && !m_owns;
   always_comb begin
      h_st_d = h_st_q;
      case (h_st_q)
         dmabi_pkg::H_IDLE: if (host_go) h_st_d = dmabi_pkg::H_STB;
         dmabi_pkg::H_STB: h_st_d = dmabi_pkg::H_ACK;
         dmabi_pkg::H_ACK: if (as_s) h_st_d = dmabi_pkg::H_IDLE;
         default: h_st_d = dmabi_pkg::H_IDLE;
      endcase
   end
   wire h_busy_d = h_st_d != dmabi_pkg::H_IDLE;
   wire h_ack_d = h_st_d == dmabi_pkg::H_ACK;
   wire h_rd = rw_s;

   // ---------------------------------------------------------------
   // Bus master sequencer
   // ---------------------------------------------------------------
   logic [23:1] cyc_addr_q;
   logic [15:0] cyc_wdata_q;
   logic [2:0] cyc_fc_q;
   logic cyc_wr_q, cyc_up_q, cyc_lo_q, cyc_hib_q;
   logic buf_ready;
   wire take = req_valid && req_ready && (m_st_q == dmabi_pkg::M_IDLE);
   wire in_data = m_st_q == dmabi_pkg::M_DATA;
   wire self_sel = in_data && !cs_s;
   wire exc_end = in_data && cs_s && exc_taken(bec_s);
   wire ok_end = in_data && cs_s && !exc_taken(bec_s) && !transfer_acknowledge_s;
   always_comb begin
      m_st_d = m_st_q;
      case (m_st_q)
         dmabi_pkg::M_IDLE: if (take) m_st_d = dmabi_pkg::M_REQ;
         dmabi_pkg::M_REQ: if (!bg_s) m_st_d = dmabi_pkg::M_WAIT;
         // Wait for previous master to let go
         dmabi_pkg::M_WAIT: if (as_s && grant_acknowledge_s && h_st_q == dmabi_pkg::H_IDLE && !host_go)
            m_st_d = dmabi_pkg::M_ADDR;
         dmabi_pkg::M_ADDR: m_st_d = dmabi_pkg::M_DATA;
         dmabi_pkg::M_DATA: if (self_sel || exc_end || ok_end) m_st_d = dmabi_pkg::M_END;
         dmabi_pkg::M_END: m_st_d = dmabi_pkg::M_IDLE;
         default: m_st_d = dmabi_pkg::M_IDLE;
      endcase
   end
   // Owning states form bus master mode
   wire own_d = (m_st_d == dmabi_pkg::M_ADDR) || (m_st_d == dmabi_pkg::M_DATA) ||
                (m_st_d == dmabi_pkg::M_END);
   wire adr_d = m_st_d == dmabi_pkg::M_ADDR;
   wire dat_d = m_st_d == dmabi_pkg::M_DATA;
   // One mode from the two sequencers
   wire dmabi_pkg::dmabi_mode_t mode_d = own_d ? dmabi_pkg::DMABI_MASTER :
      h_busy_d ? dmabi_pkg::DMABI_HOST : dmabi_pkg::DMABI_IDLE;
   // Upper address then data on shared pins
   wire [15:0] ad_d = adr_d ? cyc_addr_q[23:`DMABI_ADDR_HI_LSB] :
                      dat_d ? cyc_wdata_q : reg_rdata;
   wire ad_oe_d = adr_d || (dat_d && cyc_wr_q) || (h_ack_d && h_rd);
   // Buffer controls serve both active modes
   wire data_buffer_enable_out_d = !((dat_d) || h_ack_d);
   wire data_direction_out_d = own_d ? cyc_wr_q : h_rd;

   // ---------------------------------------------------------------
   // Start pulse
   // ---------------------------------------------------------------
   logic [2:0] start_cnt_q;

   // ---------------------------------------------------------------
   // State and request capture
   // ---------------------------------------------------------------
   // Reset lands in idle with nothing pending
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         m_st_q <= dmabi_pkg::M_IDLE;
         h_st_q <= dmabi_pkg::H_IDLE;
      end else begin
         m_st_q <= m_st_d;
         h_st_q <= h_st_d;
      end
   end
   always_ff @(posedge clk) begin
      if (take) begin
         cyc_addr_q <= req_addr;
         cyc_wdata_q <= req_wdata;
         cyc_fc_q <= req_fc;
         cyc_wr_q <= req_write;
         cyc_up_q <= req_upper;
         cyc_lo_q <= req_lower;
         cyc_hib_q <= req_upper_byte_route;
      end
   end
   // Read requests wait for buffer room so no word is dropped
   always_ff @(posedge clk) begin
      if (sys_rst) req_ready <= 1'b0;
      else req_ready <= (m_st_d == dmabi_pkg::M_IDLE) && !take && buf_ready && !h_busy_d;
   end

   // ---------------------------------------------------------------
   // Pin drivers
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode <= dmabi_pkg::DMABI_IDLE;
         ad_oe <= 1'b0;
         addr_lo_oe <= 1'b0;
         address_strobe_n_oe <= 1'b0;
         byte_strobe_oe <= 1'b0;
         rw_oe <= 1'b0;
         transfer_acknowledge_n_oe <= 1'b0;
         upper_address_latch_strobe_n_oe <= 1'b0;
         own_n_oe <= 1'b0;
         data_direction_out_oe <= 1'b0;
         data_buffer_enable_out_n_oe <= 1'b0;
         upper_byte_route_n_oe <= 1'b0;
         function_code_out_oe <= 1'b0;
         transfer_complete_out_n_oe <= 1'b0;
         grant_acknowledge_n_oe <= 1'b0;
      end else begin
         mode <= mode_d;
         ad_oe <= ad_oe_d;
         // Low address out only while master
         addr_lo_oe <= own_d;
         // Strobes are outputs only in own cycles
         address_strobe_n_oe <= own_d;
         byte_strobe_oe <= own_d;
         // Direction line output as master only
         rw_oe <= own_d;
         // Acknowledge line owned in host mode
         transfer_acknowledge_n_oe <= h_busy_d;
         upper_address_latch_strobe_n_oe <= own_d;
         own_n_oe <= own_d;
         data_direction_out_oe <= own_d || h_busy_d;
         data_buffer_enable_out_n_oe <= own_d || h_busy_d;
         // Route line floats outside master mode
         upper_byte_route_n_oe <= own_d;
         // Codes only during own address and data phases
         function_code_out_oe <= adr_d || dat_d;
         transfer_complete_out_n_oe <= own_d;
         grant_acknowledge_n_oe <= own_d;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ad_o <= 16'h0000;
         addr_lo_o <= 7'h00;
         address_strobe_n_o <= 1'b1;
         upper_byte_strobe_n_o <= 1'b1;
         lower_byte_strobe_n_o <= 1'b1;
         rw_o <= 1'b1;
         transfer_acknowledge_n_o <= 1'b1;
         upper_address_latch_strobe_n_o <= 1'b1;
         own_n_o <= 1'b1;
         data_direction_out_o <= 1'b0;
         data_buffer_enable_out_n_o <= 1'b1;
         upper_byte_route_n_o <= 1'b1;
         function_code_out_o <= 3'h0;
         transfer_complete_out_n_o <= 1'b1;
         grant_acknowledge_n_o <= 1'b1;
         bus_request_n_o <= 1'b1;
      end else begin
         ad_o <= ad_d;
         addr_lo_o <= cyc_addr_q[7:1];
         address_strobe_n_o <= !(adr_d || dat_d);
         upper_byte_strobe_n_o <= !(dat_d && cyc_up_q);
         lower_byte_strobe_n_o <= !(dat_d && cyc_lo_q);
         rw_o <= !cyc_wr_q;
         transfer_acknowledge_n_o <= !h_ack_d;
         upper_address_latch_strobe_n_o <= !adr_d;
         own_n_o <= !own_d;
         data_direction_out_o <= data_direction_out_d;
         data_buffer_enable_out_n_o <= data_buffer_enable_out_d;
         // Byte on upper lanes is routed down
         upper_byte_route_n_o <= !(dat_d && cyc_hib_q);
         function_code_out_o <= cyc_fc_q;
         transfer_complete_out_n_o <= !ok_end;
         grant_acknowledge_n_o <= !own_d;
         bus_request_n_o <= !((m_st_d == dmabi_pkg::M_REQ) || (m_st_d == dmabi_pkg::M_WAIT));
      end
   end

   // ---------------------------------------------------------------
   // Cycle results and register access
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cyc_done <= 1'b0;
         bus_err <= 1'b0;
         addr_err <= 1'b0;
         reg_stb <= 1'b0;
      end else begin
         cyc_done <= ok_end;
         bus_err <= exc_end;
         addr_err <= self_sel;
         reg_stb <= (h_st_q == dmabi_pkg::H_IDLE) && host_go;
      end
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         reg_write <= 1'b0;
         reg_interrupt_acknowledge_in <= 1'b0;
         reg_addr <= 8'h00;
         reg_wdata <= 16'h0000;
      end else if ((h_st_q == dmabi_pkg::H_IDLE) && host_go) begin
         reg_write <= !rw_s;
         reg_interrupt_acknowledge_in <= cs_s;
         // Only lower strobe means odd byte
         reg_addr <= {alo_s, uds_s && !lds_s};
         reg_wdata <= ad_s;
      end
   end
   // Start pulse held low four clocks
   always_ff @(posedge clk) begin
      if (sys_rst) start_cnt_q <= 3'h0;
      else if (start_cfg && start_trig && start_cnt_q == 3'h0) start_cnt_q <= `DMABI_START_LOW_CLKS;
      else if (start_cnt_q != 3'h0) start_cnt_q <= start_cnt_q - 3'h1;
   end
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         peripheral_control_line_n_o <= 1'b1;
         peripheral_control_line_n_oe <= 1'b0;
      end else begin
         peripheral_control_line_n_o <= !((start_cfg && start_trig && start_cnt_q == 3'h0) ||
                                          start_cnt_q > 3'h1);
         peripheral_control_line_n_oe <= start_cfg;
      end
   end
   dmabi_skid #(.W(`DMABI_BUF_W)) u_buf (
      .clk(clk),
      .sys_rst(sys_rst),
      .in_valid(ok_end && !cyc_wr_q),
      .in_ready(buf_ready),
      .in_data(ad_s),
      .out_valid(rd_valid),
      .out_ready(rd_ready),
      .out_data(rd_data)
   );

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   chk_mode_excl: assert property (!(m_owns && h_st_q != dmabi_pkg::H_IDLE))
      else $error("host and master active together");
   chk_host_entry: assert property ((h_st_q == dmabi_pkg::H_IDLE && host_go)
      |=> reg_stb ##1 (mode == dmabi_pkg::DMABI_HOST && !transfer_acknowledge_n_o))
      else $error("host access not acknowledged");
   chk_fc_window: assert property (function_code_out_oe |-> (mode == dmabi_pkg::DMABI_MASTER
      && !address_strobe_n_o))
      else $error("function code driven outside own cycle");
   chk_self_select: assert property (self_sel |=> addr_err && transfer_complete_out_n_o)
      else $error("self select not aborted");
   chk_uas_float: assert property (mode != dmabi_pkg::DMABI_MASTER
      |-> !upper_address_latch_strobe_n_oe && !upper_byte_route_n_oe)
      else $error("latch strobe driven outside master");
   chk_own_span: assert property (mode == dmabi_pkg::DMABI_MASTER
      |-> own_n_oe && !own_n_o && !grant_acknowledge_n_o)
      else $error("ownership not asserted as master");
   chk_idle_float: assert property (mode == dmabi_pkg::DMABI_IDLE |-> !rw_oe
      && !data_direction_out_oe && !data_buffer_enable_out_n_oe && !transfer_acknowledge_n_oe)
      else $error("line driven in idle");
   chk_start_width: assert property ($fell(peripheral_control_line_n_o)
      |-> !peripheral_control_line_n_o [*4] ##1 peripheral_control_line_n_o)
      else $error("start pulse not four clocks");
   chk_grant_wait: assert property ((m_st_q == dmabi_pkg::M_WAIT && !(as_s && grant_acknowledge_s))
      |=> own_n_o)
      else $error("bus taken while previous master active");
   chk_exc_wins: assert property (exc_end |=> bus_err && transfer_complete_out_n_o
      ##1 mode == dmabi_pkg::DMABI_IDLE)
      else $error("acknowledge taken over exception");
   chk_dtc_pulse: assert property (ok_end |=> !transfer_complete_out_n_o
      ##1 transfer_complete_out_n_o)
      else $error("transfer complete not one pulse");
   cov_read_cycle: cover property (ok_end && !cyc_wr_q);
   cov_write_cycle: cover property (ok_end && cyc_wr_q);
   cov_host_read: cover property (reg_stb && !reg_write);
   cov_buf_full: cover property (!buf_ready);
endmodule

/* File: rtl/dmabi_map.svh */
// Constants for the DMA bus interface and mode control
`ifndef DMABI_MAP_SVH
`define DMABI_MAP_SVH
// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define DMABI_START_LOW_CLKS 3'h4
// ---------------------------------------------------------------
// Exception codes (active low lines)
// ---------------------------------------------------------------
`define DMABI_BEC_NONE 3'h7
`define DMABI_BEC_HALT 3'h6
// ---------------------------------------------------------------
// Field positions and widths
// ---------------------------------------------------------------
`define DMABI_ADDR_HI_LSB 8
`define DMABI_IN_A_W 31
`define DMABI_IN_B_W 4
`define DMABI_BUF_W 16
`endif

/* File: rtl/dmabi_pkg.sv */
// Types for the DMA bus interface and mode control
package dmabi_pkg;
   typedef enum logic [1:0] {DMABI_IDLE, DMABI_HOST, DMABI_MASTER} dmabi_mode_t;
   typedef enum logic [2:0] {M_IDLE, M_REQ, M_WAIT, M_ADDR, M_DATA, M_END} dmabi_mst_t;
   typedef enum logic [1:0] {H_IDLE, H_STB, H_ACK} dmabi_hst_t;
endpackage

/* File: rtl/dmabi_sync.sv */
// Two-stage pin synchroniser, first stage on either clock edge
module dmabi_sync #(
   parameter int W = 1,
   parameter bit FALL = 1'b0
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Pins in, synchronised out
   input wire logic [W-1:0] pin_i,
   output logic [W-1:0] sync_o
);
   logic [W-1:0] meta_q;
   // ---------------------------------------------------------------
   // First stage, read only by the second
   // ---------------------------------------------------------------
   generate
      if (FALL) begin : g_fall
         always_ff @(negedge clk) begin
            if (sys_rst) meta_q <= '1;
            else meta_q <= pin_i;
         end
      end else begin : g_rise
         always_ff @(posedge clk) begin
            if (sys_rst) meta_q <= '1;
            else meta_q <= pin_i;
         end
      end
   endgenerate
   always_ff @(posedge clk) begin
      if (sys_rst) sync_o <= '1;
      else sync_o <= meta_q;
   end
endmodule

/* File: rtl/dmabi_skid.sv */
// Two-entry buffer with valid and ready on both sides
module dmabi_skid #(
   parameter int W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   logic [W-1:0] mem_q [2];
   logic [1:0] v_q;
   wire push = in_valid && !v_q[1];
   wire pop = v_q[0] && out_ready;
   assign in_ready = !v_q[1];
   assign out_valid = v_q[0];
   assign out_data = mem_q[0];
   // ---------------------------------------------------------------
   // Head always in entry zero
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         v_q <= 2'h0;
      end else if (pop && v_q[1]) begin
         mem_q[0] <= mem_q[1];
         if (push) mem_q[1] <= in_data;
         v_q[1] <= push;
      end else if (pop) begin
         if (push) mem_q[0] <= in_data;
         v_q[0] <= push;
      end else if (push && !v_q[0]) begin
         mem_q[0] <= in_data;
         v_q[0] <= 1'b1;
      end else if (push) begin
         mem_q[1] <= in_data;
         v_q[1] <= 1'b1;
      end
   end
endmodule

/* File: test/dmabi_bus_model.sv */
// Arbiter and memory stand-in on the far side of the system bus
module dmabi_bus_model (
   // Clock
   input wire logic clk,
   // Bus side
   input wire logic bus_request_n_o,
   input wire logic own_n_o,
   input wire logic address_strobe_n_o,
   output logic bus_grant_in_n = 1'b1,
   output logic transfer_acknowledge_n,
   output logic [15:0] rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] wait_q = 3'h0;
   // grant dropped once ownership is seen
   always @(posedge clk) begin
      bus_grant_in_n <= !(!bus_request_n_o && own_n_o);
      wait_q <= address_strobe_n_o ? 3'h0 : wait_q + 3'h1;
   end
   // slow memory: answers after four wait states
   assign transfer_acknowledge_n = !(wait_q > 3'h3);
   // Released lines show the inverse, never stale data
   assign rdata = transfer_acknowledge_n ? 16'h5aa5 : 16'ha55a;
endmodule

/* File: test/test_dmabi_top.sv */
// Self-checking bench for the bus interface and mode control
module test_dmabi_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, sys_rst = 1, h_as = 1, m_transfer_acknowledge, bus_grant_in_n, rw_i = 0, start_cfg = 0;
   logic chip_select_n = 1, start_trig = 0, req_valid = 0, req_write = 0, rd_ready = 1;
   logic upper_byte_strobe_n_i = 0, lower_byte_strobe_n_i = 0, vec_pending = 0, req_upper = 1;
   logic interrupt_acknowledge_in_n = 1, peripheral_control_line_n_i = 1, req_lower = 1;
   logic req_upper_byte_route = 0;
   logic [15:0] m_data, ad_o, rd_data, reg_wdata, req_wdata = 16'h1234, reg_rdata = 16'h00c3;
   logic [6:0] addr_lo_i = 7'h15, addr_lo_o;
   logic [2:0] bus_exception_code_n = 3'h7, req_fc = 3'h5, function_code_out_o;
   logic [23:1] req_addr = 23'h012345;
   logic [7:0] reg_addr;
   logic ad_oe, addr_lo_oe, address_strobe_n_o, address_strobe_n_oe, upper_byte_strobe_n_o;
   logic lower_byte_strobe_n_o, byte_strobe_oe, rw_o, rw_oe, transfer_acknowledge_n_o;
   logic transfer_acknowledge_n_oe, upper_address_latch_strobe_n_o, own_n_o, own_n_oe;
   logic upper_address_latch_strobe_n_oe, data_direction_out_o, data_direction_out_oe;
   logic data_buffer_enable_out_n_o, data_buffer_enable_out_n_oe, upper_byte_route_n_o;
   logic upper_byte_route_n_oe, function_code_out_oe, transfer_complete_out_n_o, rd_valid;
   logic transfer_complete_out_n_oe, bus_request_n_o, grant_acknowledge_n_o, reg_interrupt_acknowledge_in;
   logic grant_acknowledge_n_oe, peripheral_control_line_n_o, peripheral_control_line_n_oe;
   logic req_ready, cyc_done, bus_err, addr_err, reg_stb, reg_write;
   dmabi_pkg::dmabi_mode_t mode;
   int error_cnt = 0, checks = 0, i, n;
   // ----------------------------------------
   // Wire levels from all drivers
   // ----------------------------------------
   wire logic [15:0] ad_i = ad_oe ? ad_o : m_data;
   wire logic address_strobe_n_i = address_strobe_n_oe ? address_strobe_n_o : h_as;
   wire logic transfer_acknowledge_n_i = transfer_acknowledge_n_oe ? transfer_acknowledge_n_o : m_transfer_acknowledge;
   wire logic grant_acknowledge_n_i = grant_acknowledge_n_oe ? grant_acknowledge_n_o : 1'b1;
   dmabi_top u_dmabi_top (.*);
   dmabi_bus_model u_dmabi_bus_model (.clk(clk), .bus_request_n_o(bus_request_n_o),
      .own_n_o(own_n_o), .address_strobe_n_o(address_strobe_n_o),
      .bus_grant_in_n(bus_grant_in_n), .transfer_acknowledge_n(m_transfer_acknowledge), .rdata(m_data));
   always #5 clk = ~clk;
   task automatic check(input logic [15:0] seen, exp);
      checks++;
      if (seen !== exp) begin
         error_cnt++;
         $display("ERROR at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   // Bound ran out: count it and stop
   task automatic need(input int k);
      if (k >= 60) begin
         error_cnt++;
         tally_and_finish();
      end
   endtask
   task automatic master_cycle(input logic cs_hit, input logic [2:0] bec, input logic exc);
      @(posedge clk) req_valid <= 1;
      for (i = 0; i < 60 && req_ready !== 1; i++) @(negedge clk);
      need(i);
      @(posedge clk) req_valid <= 0;
      for (i = 0; i < 60 && own_n_o !== 0; i++) @(negedge clk);
      need(i);
      check(mode, dmabi_pkg::DMABI_MASTER);
      check(function_code_out_o, req_fc);
      check(ad_o, req_addr[23:8]);
      check(upper_address_latch_strobe_n_oe, 1);
      check({rw_o, addr_lo_o}, {!req_write, req_addr[7:1]});
      @(posedge clk) begin
         chip_select_n <= !cs_hit;
         bus_exception_code_n <= bec;
      end
      for (i = 0; i < 60 && (cyc_done | addr_err | bus_err) !== 1; i++) @(negedge clk);
      need(i);
      check(addr_err, cs_hit);
      check(bus_err, exc);
      check(transfer_complete_out_n_o, cs_hit || exc);
      check(rd_valid, !cs_hit && !exc);
      if (!cs_hit && !exc) check(rd_data, 16'ha55a);
      @(posedge clk) begin
         chip_select_n <= 1;
         bus_exception_code_n <= 3'h7;
      end
      for (i = 0; i < 60 && mode !== dmabi_pkg::DMABI_IDLE; i++) @(negedge clk);
      need(i);
      check({own_n_oe, function_code_out_oe}, 0);
   endtask
   task automatic host_write(input logic vec);
      @(posedge clk) begin
         chip_select_n <= vec;
         interrupt_acknowledge_in_n <= !vec;
         vec_pending <= vec;
         rw_i <= vec;
         h_as <= 0;
      end
      for (i = 0; i < 60 && reg_stb !== 1; i++) @(negedge clk);
      need(i);
      check({reg_write, reg_addr}, {!vec, 8'h2a});
      check(reg_interrupt_acknowledge_in, vec);
      for (i = 0; i < 60 && transfer_acknowledge_n_o !== 0; i++) @(negedge clk);
      need(i);
      check(mode, dmabi_pkg::DMABI_HOST);
      check({own_n_oe, upper_byte_route_n_oe, data_direction_out_oe}, 3'h1);
      check({ad_oe, data_direction_out_o}, {vec, vec});
      if (vec) check(ad_o, 16'h00c3);
      @(posedge clk) h_as <= 1;
      @(posedge clk) begin
         chip_select_n <= 1;
         interrupt_acknowledge_in_n <= 1;
         vec_pending <= 0;
         rw_i <= 0;
      end
      for (i = 0; i < 60 && mode !== dmabi_pkg::DMABI_IDLE; i++) @(negedge clk);
      need(i);
      check(transfer_acknowledge_n_oe, 0);
   endtask
   task automatic start_pulse;
      @(posedge clk) start_cfg <= 1;
      @(posedge clk) start_trig <= 1;
      @(posedge clk) start_trig <= 0;
      n = 0;
      repeat (12) @(negedge clk) n += !peripheral_control_line_n_o;
      check(n, 4);
   endtask
   initial begin
      repeat (16) @(posedge clk);
      sys_rst <= 0;
      @(negedge clk) check(mode, dmabi_pkg::DMABI_IDLE);
      check({data_direction_out_oe, data_buffer_enable_out_n_oe, rw_oe}, 0);
      master_cycle(0, 3'h7, 0);
      host_write(0);
      master_cycle(1, 3'h7, 0);
      master_cycle(0, 3'h5, 1);
      master_cycle(0, 3'h6, 0);
      host_write(1);
      start_pulse();
      tally_and_finish();
   end
endmodule
